// *** verilog/fts_pkg.sv ***
// Purpose: Shared constants and carrier types for the fan speed monitor.
// Assumes: APB slave with 32-bit data, pclk at 125 MHz.
// Notes:   Offsets are byte addresses; each register is one aligned word.
package fts_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_HIGH = 12'h008;
  localparam logic [11:0] OFS_LOW  = 12'h00C;
  // Control field positions
  localparam int CTRL_READ_LSB = 16;
  localparam int CTRL_TOG_IE   = 15;
  localparam int CTRL_RDY_IE   = 14;
  localparam int CTRL_EDGE_LSB = 11;
  localparam int CTRL_MODE     = 10;
  localparam int CTRL_FILT     = 8;
  localparam int CTRL_EN       = 1;
  localparam int CTRL_LIM_IE   = 0;
  // Status field positions
  localparam int STAT_RDY = 3;
  localparam int STAT_TOG = 2;
  localparam int STAT_LIM = 0;
  // Reset values and limits
  localparam logic [15:0] HIGH_RST = 16'hFFFF;
  localparam logic [15:0] LOW_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  // Edge-count codes, stored as edges minus one
  localparam logic [3:0] EDGES_M1_00 = 4'h1;
  localparam logic [3:0] EDGES_M1_01 = 4'h2;
  localparam logic [3:0] EDGES_M1_10 = 4'h4;
  localparam logic [3:0] EDGES_M1_11 = 4'h8;
  // Timing: reference tick derived from pclk
  localparam int CLK_PERIOD_NS = 8;
  localparam int REF_PERIOD_NS = 10000;
  localparam int REF_DIV       = REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [10:0] REF_DIV_M1 = 11'(REF_DIV - 1);
  // Glitch filter: ticks an input level must persist
  localparam int FILT_TICKS = 2;
  localparam logic [1:0] FILT_TICKS_M1 = 2'(FILT_TICKS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // APB carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fts_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fts_apb_rsp_type;
endpackage : fts_pkg

// *** verilog/fts_monitor.sv ***
// Purpose: Fan tachometer speed monitor with APB register access.
// Assumes: fan_speed_input may be asynchronous; pclk 125 MHz.
// Notes:   The 100 kHz reference is a tick derived from pclk.
// Function
// - Upper control half shows a read-only 16-bit latched counter copy.
// - Free-running mode copies counter to reading on every increment.
// - Reading never clears the counter; it wraps FFFFh to 0000h.
// - Clock mode latches on programmed edge count or counter reaching FFFFh.
// - Clock mode clears counter in the same cycle it copies it to the reading.
// - Clock mode reading FFFFh means edges missing within 655 ms.
// - Saturated FFFFh above a lower high limit raises the limit flag.
// - Control bit 15 gates the toggle event; resets to 0.
// - Control bit 14 gates the reading-ready event; resets to 0.
// - Bits 12:11 pick 2, 3, 5 or 9 edges; reset 00b.
// - Clock mode counts reference periods across the selected edges.
// - Mode bit 10 set counts reference ticks, latching at edge count.
// - Mode bit clear counts each rising edge of the speed input.
// - Bit 8 set drops input pulses that do not span two reference ticks.
// - Ready flag sets on clock-mode latch, write-1 clears, zero in mode 0.
// - Limit flag sets when reading passes high or low limit.
// - Event output is the OR of enabled status flags.
// - Run enable freezes the block; resuming keeps previous counter state.
`timescale 1ns/1ps
module fts_monitor (
  input  wire logic                     pclk,            // 125 MHz clock
  input  wire logic                     presetn,         // Async reset, low
  input  wire fts_pkg::fts_apb_req_type apb_req,         // APB request
  output      fts_pkg::fts_apb_rsp_type apb_rsp,         // APB answer
  input  wire logic                     fan_speed_input, // Fan speed pin
  output      logic                     speed_event      // Block event
);
  import fts_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] reading;
    logic        tog_ie;
    logic        rdy_ie;
    logic [1:0]  edges;
    logic        mode;
    logic        filt_en;
    logic        en;
    logic        lim_ie;
    logic        st_rdy;
    logic        st_tog;
    logic        st_lim;
    logic [15:0] high;
    logic [15:0] low;
    logic [15:0] cnt;
    logic [3:0]  edge_cnt;
    logic [10:0] div;
    logic        sync1;
    logic        sync2;
    logic        filt;
    logic        filt_prev;
    logic [1:0]  stab;
    logic [31:0] prdata;
  } fts_state_type;

  fts_state_type st;
  fts_state_type next_st;
  logic          wr;
  logic          setup;
  logic          tick;
  logic          tgl;
  logic          rise;
  logic          lat_edge;
  logic          lat_sat;
  logic          lat;
  logic          over;

  //////////////////////////////////////////////////////////////////////////////
  // Decoders
  function automatic logic [3:0] edges_m1(input logic [1:0] code);
    case (code)
      2'h0:    edges_m1 = EDGES_M1_00;
      2'h1:    edges_m1 = EDGES_M1_01;
      2'h2:    edges_m1 = EDGES_M1_10;
      default: edges_m1 = EDGES_M1_11;
    endcase
  endfunction : edges_m1

  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == OFS_CTRL) || (a == OFS_STAT) ||
              (a == OFS_HIGH) || (a == OFS_LOW);
  endfunction : reg_hit

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st  = st;
    wr       = apb_req.psel & apb_req.penable & apb_req.pwrite;
    setup    = apb_req.psel & ~apb_req.penable;
    tick     = st.en && (st.div == REF_DIV_M1);
    tgl      = st.en && (st.filt != st.filt_prev);
    rise     = tgl && st.filt;
    lat_edge = 1'b0;
    lat_sat  = 1'b0;
    over     = (st.reading > st.high) || (st.reading < st.low);

    // Reference tick divider and input synchroniser
    if (st.en) begin
      next_st.div       = tick ? 11'h000 : 11'(st.div + 11'h001);
      next_st.sync1     = fan_speed_input;
      next_st.sync2     = st.sync1;
      next_st.filt_prev = st.filt;
    end

    // Glitch filter: new level must persist over two ticks
    if (st.en) begin
      if (!st.filt_en || (st.sync2 == st.filt)) begin
        next_st.stab = 2'h0;
        if (!st.filt_en) begin
          next_st.filt = st.sync2;
        end
      end else if (tick) begin
        if (st.stab == FILT_TICKS_M1) begin
          next_st.filt = st.sync2;
          next_st.stab = 2'h0;
        end else begin
          next_st.stab = 2'(st.stab + 2'h1);
        end
      end
    end

    // Counting
    if (!st.mode) begin
      next_st.edge_cnt = 4'h0;
      if (rise) begin
        next_st.cnt     = 16'(st.cnt + 16'h0001);
        next_st.reading = 16'(st.cnt + 16'h0001);
      end
    end else begin
      if (tgl) begin
        if (st.edge_cnt == 4'h0) begin
          next_st.edge_cnt = 4'h1;
          next_st.cnt      = 16'h0000;
        end else if (st.edge_cnt == edges_m1(st.edges)) begin
          lat_edge         = 1'b1;
          next_st.edge_cnt = 4'h1;
        end else begin
          next_st.edge_cnt = 4'(st.edge_cnt + 4'h1);
        end
      end
      lat_sat = tick && (st.cnt == CNT_MAX) && !lat_edge;
      if (lat_edge) begin
        next_st.reading = st.cnt;
        next_st.cnt     = 16'h0000;
      end else if (lat_sat) begin
        next_st.reading  = CNT_MAX;
        next_st.cnt      = 16'h0000;
        next_st.edge_cnt = 4'h0;
      end else if (tgl && st.edge_cnt == 4'h0) begin
        next_st.cnt = 16'h0000;
      end else if (tick && st.edge_cnt != 4'h0) begin
        next_st.cnt = 16'(st.cnt + 16'h0001);
      end else if (tick && st.cnt != 16'h0000) begin
        next_st.cnt = 16'(st.cnt + 16'h0001);
      end else if (tick) begin
        next_st.cnt = 16'h0001;
      end
    end
    lat = lat_edge | lat_sat;

    // Status flags: set wins over write-one clear
    next_st.st_rdy = st.mode & ((st.st_rdy & ~(wr && apb_req.paddr == OFS_STAT
                     && apb_req.pwdata[STAT_RDY])) | lat);
    next_st.st_tog = (st.st_tog & ~(wr && apb_req.paddr == OFS_STAT
                     && apb_req.pwdata[STAT_TOG])) | tgl;
    next_st.st_lim = (st.st_lim & ~(wr && apb_req.paddr == OFS_STAT
                     && apb_req.pwdata[STAT_LIM])) | over;

    // Register writes; reading field is not writable
    if (wr) begin
      case (apb_req.paddr)
        OFS_CTRL: begin
          next_st.tog_ie  = apb_req.pwdata[CTRL_TOG_IE];
          next_st.rdy_ie  = apb_req.pwdata[CTRL_RDY_IE];
          next_st.edges   = apb_req.pwdata[CTRL_EDGE_LSB+:2];
          next_st.mode    = apb_req.pwdata[CTRL_MODE];
          next_st.filt_en = apb_req.pwdata[CTRL_FILT];
          next_st.en      = apb_req.pwdata[CTRL_EN];
          next_st.lim_ie  = apb_req.pwdata[CTRL_LIM_IE];
        end
        OFS_HIGH: next_st.high = apb_req.pwdata[15:0];
        OFS_LOW:  next_st.low  = apb_req.pwdata[15:0];
        default:  next_st.high = st.high;
      endcase
    end

    // Read data captured in the setup phase
    if (setup) begin
      case (apb_req.paddr)
        OFS_CTRL: begin
          next_st.prdata = 32'h0000_0000;
          next_st.prdata[CTRL_READ_LSB+:16] = st.reading;
          next_st.prdata[CTRL_TOG_IE]       = st.tog_ie;
          next_st.prdata[CTRL_RDY_IE]       = st.rdy_ie;
          next_st.prdata[CTRL_EDGE_LSB+:2]  = st.edges;
          next_st.prdata[CTRL_MODE]         = st.mode;
          next_st.prdata[CTRL_FILT]         = st.filt_en;
          next_st.prdata[CTRL_EN]           = st.en;
          next_st.prdata[CTRL_LIM_IE]       = st.lim_ie;
        end
        OFS_STAT: begin
          next_st.prdata = 32'h0000_0000;
          next_st.prdata[STAT_RDY] = st.st_rdy;
          next_st.prdata[STAT_TOG] = st.st_tog;
          next_st.prdata[STAT_LIM] = st.st_lim;
        end
        OFS_HIGH: next_st.prdata = {16'h0000, st.high};
        OFS_LOW:  next_st.prdata = {16'h0000, st.low};
        default:  next_st.prdata = 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st      <= '0;
      st.high <= HIGH_RST;
      st.low  <= LOW_RST;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign apb_rsp.prdata  = st.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~reg_hit(apb_req.paddr);
  assign speed_event = (st.st_tog & st.tog_ie) | (st.st_rdy & st.rdy_ie)
                     | (st.st_lim & st.lim_ie);

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_m1_edge_latch;
    st.mode && lat_edge;
  endsequence
  sequence s_m1_sat;
    st.mode && lat_sat;
  endsequence

  a_mode0_track: assert property (!st.mode && rise |=>
    st.reading == 16'($past(st.cnt) + 16'h0001))
    else $error("free-running reading did not track count");
  a_counter_wrap: assert property (!st.mode && rise && st.cnt == CNT_MAX
    |=> st.cnt == 16'h0000 && st.reading == 16'h0000)
    else $error("counter did not wrap to zero");
  a_edge_latch: assert property (s_m1_edge_latch |=>
    st.cnt == 16'h0000 && st.reading == $past(st.cnt) && st.st_rdy)
    else $error("edge latch did not copy and clear");
  a_sat_latch: assert property (s_m1_sat |=>
    st.reading == CNT_MAX && st.cnt == 16'h0000)
    else $error("saturated count not latched as FFFFh");
  a_ready_mode0: assert property (!st.mode |=> !st.st_rdy)
    else $error("ready flag set in free-running mode");
  a_limit_flag: assert property (st.reading > st.high |=> st.st_lim)
    else $error("limit flag missed high violation");
  a_event_or: assert property (speed_event == ((st.st_tog & st.tog_ie) |
    (st.st_rdy & st.rdy_ie) | (st.st_lim & st.lim_ie)))
    else $error("event is not OR of enabled flags");
  a_toggle_gate: assert property (st.st_tog && st.tog_ie |-> speed_event)
    else $error("enabled toggle flag gave no event");
  a_idle_freeze: assert property (!st.en ##1 !st.en |->
    $stable(st.cnt) && $stable(st.reading))
    else $error("counter moved while disabled");
  a_sync_chain: assert property (st.en |=> st.sync2 == $past(st.sync1))
    else $error("synchroniser chain broken");
  a_filter_hold: assert property (st.en && st.filt_en && tick &&
    st.sync2 != st.filt && st.stab == 2'h0 |=> $stable(st.filt))
    else $error("filter passed a one-tick pulse");

  // Status flags: write-one clear and set from events
  a_ready_clear: assert property (wr && apb_req.paddr == OFS_STAT &&
    apb_req.pwdata[STAT_RDY] && !lat |=> !st.st_rdy)
    else $error("ready flag ignored write-one clear");
  a_ready_set: assert property (st.mode && lat |=> st.st_rdy)
    else $error("latch did not set ready flag");
  a_toggle_clear: assert property (wr && apb_req.paddr == OFS_STAT &&
    apb_req.pwdata[STAT_TOG] && !tgl |=> !st.st_tog)
    else $error("toggle flag ignored write-one clear");
  a_limit_clear: assert property (wr && apb_req.paddr == OFS_STAT &&
    apb_req.pwdata[STAT_LIM] && !over |=> !st.st_lim)
    else $error("limit flag ignored write-one clear");

  // Event gating by the enable bits, and toggle flag set
  a_ready_gate: assert property (st.st_rdy && st.rdy_ie |-> speed_event)
    else $error("enabled ready flag gave no event");
  a_event_quiet: assert property (!st.tog_ie && !st.rdy_ie && !st.lim_ie
    |-> !speed_event)
    else $error("event raised with every enable off");
  a_toggle_flag: assert property (tgl |=> st.st_tog)
    else $error("input toggle did not set toggle flag");

  // Limit checks, including a stalled fan
  a_limit_low: assert property (st.reading < st.low |=> st.st_lim)
    else $error("limit flag missed low violation");
  a_sat_ready: assert property (s_m1_sat |=> st.st_rdy)
    else $error("saturated latch did not set ready");
  a_sat_window: assert property (s_m1_sat |=> st.edge_cnt == 4'h0)
    else $error("saturation did not reset the edge window");
  a_stall_limit: assert property (s_m1_sat && st.high < CNT_MAX && !wr
    |=> ##1 st.st_lim)
    else $error("stalled fan did not raise limit flag");

  // Counter movement in each mode
  a_mode0_hold: assert property (!st.mode && !rise |=> $stable(st.cnt))
    else $error("free-running counter moved without a rise");
  a_ref_count: assert property (st.mode && tick && !lat &&
    !(tgl && st.edge_cnt == 4'h0) |=> st.cnt == 16'($past(st.cnt) + 16'h0001))
    else $error("reference tick did not advance counter");
  a_window_open: assert property (st.mode && tgl && st.edge_cnt == 4'h0 &&
    !lat_sat |=> st.cnt == 16'h0000 && st.edge_cnt == 4'h1)
    else $error("first edge did not open a clean window");
  a_tick_wrap: assert property (tick |=> st.div == 11'h000)
    else $error("reference divider did not restart");

  // Run enable low freezes divider and input path
  a_div_hold: assert property (!st.en |=> $stable(st.div))
    else $error("divider moved while disabled");
  a_path_hold: assert property (!st.en |=> $stable(st.filt) && $stable(st.edge_cnt))
    else $error("input path moved while disabled");

  // Register side: read-only reading, bypassed filter, held read data
  a_reading_ro: assert property (wr && apb_req.paddr == OFS_CTRL && !st.mode &&
    !rise |=> $stable(st.reading))
    else $error("write changed the read-only reading");
  a_filter_bypass: assert property (st.en && !st.filt_en |=>
    st.filt == $past(st.sync2))
    else $error("disabled filter delayed the input");
  a_read_hold: assert property (!setup |=> $stable(apb_rsp.prdata))
    else $error("read data moved outside a setup cycle");
endmodule : fts_monitor

// *** verif/fts_fan_model.sv ***
// Purpose: Fan tach output model, a square wave of set half period.
// Assumes: Half period in pclk cycles, at least 2.
// Notes:   Stops only at low level, so every pulse leaves whole.
`timescale 1ns/1ps
module fts_fan_model (
  input  wire logic        pclk,  // Bench clock
  input  wire logic        run,   // Fan spinning
  input  wire logic [15:0] half,  // Half period in cycles
  output      logic        tach,  // Tach output
  output      int          rises  // Rising edges sent
);
  int cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Toggle each half period; a high half always runs out before stopping
  initial tach = 1'b0;
  initial rises = 0;
  always @(posedge pclk) begin
    if (run || tach) begin
      if (cnt + 1 >= int'(half)) begin
        cnt <= 0;
        tach <= ~tach;
        if (!tach) rises <= rises + 1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : fts_fan_model

// *** verif/fts_monitor_test.sv ***
// Purpose: Self-checking bench for the fan speed monitor.
// Assumes: Zero-wait APB slave; 1250 pclk per reference tick.
// Notes:   The 655 ms saturation is too long to run here.
`timescale 1ns/1ps
module fts_monitor_test;
  import fts_pkg::*;
  logic            pclk     = 1'b0;     // 125 MHz clock
  logic            presetn  = 1'b0;     // Reset, low active
  fts_apb_req_type req      = '0;       // APB request
  fts_apb_rsp_type rsp;                 // APB answer
  logic            fan;                 // Tach pin
  logic            ev;                  // Block event
  logic            run      = 1'b0;     // Fan spinning
  logic [15:0]     half     = 16'h0014; // Fan half period
  int              rises;               // Pulses sent
  int              errors   = 0;        // Mismatches
  int              compares = 0;        // Comparisons
  logic [31:0]     rd;                  // Last read data
  logic            serr;                // Last pslverr
  logic [15:0]     base;                // Earlier reading

  always #4 pclk = ~pclk;
  fts_monitor dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .fan_speed_input(fan), .speed_event(ev));
  fts_fan_model fan_i (.pclk(pclk), .run(run), .half(half), .tach(fan), .rises(rises));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and compare helpers
  task automatic stop_test();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic chk_in(string n, logic [15:0] lo, logic [15:0] hi, logic [15:0] g);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errors++;
      $display("BAD %s exp %h..%h got %h", n, lo, hi, g);
    end
  endtask : chk_in
  task automatic chk_ev(string n, logic e);
    @(negedge pclk);
    chk(n, {31'h0, e}, {31'h0, ev});
  endtask : chk_ev
  task automatic limit(int j, int lim);
    if (j == lim) begin
      errors++;
      stop_test();
    end
  endtask : limit

  ////////////////////////////////////////////////////////////////////////////
  // APB master, fan pulse burst and event wait
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    for (k = 0; rsp.pready !== 1'b1 || k == 0; k++) begin
      limit(k, 20);
      @(posedge pclk);
    end
    rd = rsp.prdata;
    serr = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic spin(int n, logic [15:0] h);
    int j;
    int k;
    half <= h;
    run <= 1'b1;
    k = rises + n;
    for (j = 0; rises < k; j++) begin
      limit(j, 60000);
      @(posedge pclk);
    end
    run <= 1'b0;
    repeat (2 * h + 3000) @(posedge pclk);
  endtask : spin
  task automatic wait_ev();
    int j;
    @(negedge pclk);
    for (j = 0; ev !== 1'b1; j++) begin
      limit(j, 30000);
      @(negedge pclk);
    end
  endtask : wait_ev

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [11:0] a [5] = '{OFS_CTRL, OFS_STAT, OFS_HIGH, OFS_LOW, 12'h010};
    logic [31:0] e [5] = '{32'h0, 32'h0, {16'h0, HIGH_RST}, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 32'h0);
      chk("reset value", e[i], rd);
    end
    chk("unmapped err", 32'h1, {31'h0, serr});
    $display("test reset done");
  endtask : t_reset
  task automatic t_free();
    apb(1'b1, OFS_CTRL, 32'hABCD0002);
    spin(5, 16'h0014);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("free count", 32'h00050002, rd);
    base = rd[31:16];
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("reread", 32'h00050002, rd);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("ready mode0", 32'h0, {31'h0, rd[STAT_RDY]});
    chk_ev("event gated", 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0);
    spin(3, 16'h0014);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("frozen", 32'h00050000, rd);
    apb(1'b1, OFS_CTRL, 32'h2);
    spin(2, 16'h0014);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("delta", 32'h2, {16'h0, rd[31:16] - base});
    $display("test free done");
  endtask : t_free
  task automatic t_toggle();
    apb(1'b1, OFS_STAT, 32'hF);
    apb(1'b1, OFS_CTRL, 32'h8002);
    chk_ev("toggle idle", 1'b0);
    spin(1, 16'h0014);
    chk_ev("toggle event", 1'b1);
    apb(1'b1, OFS_STAT, 32'h4);
    chk_ev("toggle clear", 1'b0);
    $display("test toggle done");
  endtask : t_toggle
  task automatic t_filter();
    apb(1'b0, OFS_CTRL, 32'h0);
    base = rd[31:16];
    apb(1'b1, OFS_CTRL, 32'h0102);
    spin(4, 16'h0271);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("narrow dropped", {base, 16'h0102}, rd);
    spin(2, 16'h0EA6);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("wide counted", {base + 16'h2, 16'h0102}, rd);
    $display("test filter done");
  endtask : t_filter
  task automatic t_measure();
    logic [15:0] e [4] = '{16'h2, 16'h3, 16'h5, 16'h9};
    half <= 16'h04E2;
    run <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, OFS_CTRL, 32'h4402 | (c << 11));
      repeat (2) begin
        apb(1'b1, OFS_STAT, 32'h8);
        wait_ev();
      end
      apb(1'b0, OFS_CTRL, 32'h0);
      chk_in("window", e[c] - 16'h2, e[c], rd[31:16]);
      apb(1'b0, OFS_STAT, 32'h0);
      chk("ready set", 32'h1, {31'h0, rd[STAT_RDY]});
      apb(1'b1, OFS_STAT, 32'h8);
      chk_ev("ready clear", 1'b0);
    end
    $display("test measure done");
  endtask : t_measure
  task automatic t_limit();
    apb(1'b1, OFS_CTRL, 32'h1C03);
    apb(1'b1, OFS_HIGH, 32'h3);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("over high", 32'h1, {31'h0, rd[STAT_LIM]});
    chk_ev("limit event", 1'b1);
    apb(1'b1, OFS_HIGH, 32'hFFFF);
    apb(1'b1, OFS_STAT, 32'h1);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("in range", 32'h0, {31'h0, rd[STAT_LIM]});
    apb(1'b1, OFS_LOW, 32'h20);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("under low", 32'h1, {31'h0, rd[STAT_LIM]});
    run <= 1'b0;
    $display("test limit done");
  endtask : t_limit

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_free();
    t_toggle();
    t_filter();
    t_measure();
    t_limit();
    stop_test();
  end
endmodule : fts_monitor_test
